// ===== testbench/agts_partner.sv
`timescale 1ns/1ps
`default_nettype none
module agts_partner
  import agts_pkg::*;
(
  input  wire logic                        clk,      // clock
  input  wire logic                        src_en_n, // source common
  input  wire logic signed [31:0]          feet,     // encoder altitude
  input  wire logic                        ovr_en,   // raw code select
  input  wire logic [agts_pkg::CODE_W-1:0] ovr,      // raw code
  output logic [agts_pkg::CODE_W-1:0]      alt_code, // code lines
  input  wire logic [agts_pkg::CODE_W-1:0] par_o,    // port pin drive
  input  wire logic [agts_pkg::CODE_W-1:0] par_oe,   // port sink enable
  output logic [agts_pkg::CODE_W-1:0]      par_pin,  // pulled-up level
  input  wire logic                        txd,      // serial line
  input  wire logic [15:0]                 rx_div    // bit time, cycles
);
  logic [7:0] rx_q[$];
  int         frame_err;
  logic [7:0] rx_b;

  // ==========================================
  // altitude encoder
  function automatic logic [CODE_W-1:0] enc(input int ft);
    int         n;
    int         c;
    logic [7:0] h;
    logic [7:0] g;
    n = ft / 100 + 12;
    h = 8'(n / 5);
    c = n % 5 + 1;
    if (h[0]) c = 6 - c;
    g = h ^ (h >> 1);
    case (c)
      1: return {g, 3'b001};
      2: return {g, 3'b011};
      3: return {g, 3'b010};
      4: return {g, 3'b110};
      default: return {g, 3'b100};
    endcase
  endfunction

  // switched-off source floats, reads as not asserted
  assign alt_code = src_en_n ? '0 : (ovr_en ? ovr : enc(feet));
  // transponder pull-up on the sink outputs
  assign par_pin = (par_oe & par_o) | ~par_oe;

  // ==========================================
  // serial receiver, mid-bit sampling
  initial frame_err = 0;
  always begin
    @(negedge txd);
    repeat (rx_div / 2) @(posedge clk);
    if (txd !== 1'b0) frame_err++;
    for (int i = 0; i < 8; i++) begin
      repeat (rx_div) @(posedge clk);
      rx_b[i] = txd;
    end
    repeat (rx_div) @(posedge clk);
    if (txd !== 1'b1) frame_err++;
    rx_q.push_back(rx_b);
  end
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import agts_pkg::*;
  localparam int SLOW  = 16;
  localparam int FAST  = 8;
  localparam int UPD   = 3000;
  localparam int LIMIT = 80000;
  logic              MCLK, RSTN, SRC_EN_N, PROTO_SEL, STROBE_N, TXD1, TXD2;
  logic [CODE_W-1:0] ALT_CODE, PAR1_O, PAR1_OE, PAR2_O, PAR2_OE, pin1, ovr;
  logic signed [31:0] feet;
  logic              ovr_en, wiggle;
  logic [15:0]       rx_div;
  logic [7:0]        exp_q[$];
  int                fail_count, samples_checked, cyc;
  logic [CODE_W-1:0] codes[5] = '{11'h7FF, 11'h555, 11'h2AA, 11'h001, 11'h400};

  agts_top #(.BAUD_DIV_SLOW(SLOW), .BAUD_DIV_FAST(FAST), .UPDATE_CYCLES(UPD))
  agts_top_inst (.MCLK(MCLK), .RSTN(RSTN), .ALT_CODE(ALT_CODE),
    .SRC_EN_N(SRC_EN_N), .PROTO_SEL(PROTO_SEL), .STROBE_N(STROBE_N),
    .PAR1_O(PAR1_O), .PAR1_OE(PAR1_OE), .PAR2_O(PAR2_O),
    .PAR2_OE(PAR2_OE), .TXD1(TXD1), .TXD2(TXD2));

  agts_partner agts_partner_inst (.clk(MCLK), .src_en_n(SRC_EN_N),
    .feet(feet), .ovr_en(ovr_en), .ovr(ovr), .alt_code(ALT_CODE),
    .par_o(PAR1_O), .par_oe(PAR1_OE), .par_pin(pin1), .txd(TXD1),
    .rx_div(rx_div));

  // ==========================================
  // clock, watchdog, common checks
  initial MCLK = 1'b0;
  always #5 MCLK = ~MCLK;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checked=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge MCLK) begin
    cyc++;
    if (cyc == LIMIT) begin
      fail_count++;
      print_verdict();
    end
  end

  always @(negedge MCLK) if (RSTN) check(TXD1, TXD2);
  always @(negedge MCLK) if (wiggle) STROBE_N <= ~STROBE_N;

  task automatic wait_idle();
    int k;
    k = 0;
    while (k < 240) begin
      @(posedge MCLK);
      k = (TXD1 === 1'b1) ? k + 1 : 0;
    end
    @(negedge MCLK);
    agts_partner_inst.rx_q.delete();
    agts_partner_inst.frame_err = 0;
  endtask

  // ==========================================
  // expected message text
  function automatic logic [7:0] hexc(input logic [3:0] d);
    return (d < 10) ? 8'h30 + d : 8'h37 + d;
  endfunction

  task automatic build(input int ft, input bit dflt);
    int         mag;
    logic [7:0] s;
    mag = (ft < 0) ? -ft : ft;
    if (dflt) exp_q = {CH_HASH, CH_A, CH_L, (ft < 0) ? CH_MINUS : CH_PLUS};
    else exp_q = {CH_A, CH_L, CH_T, CH_SP};
    for (int k = 10000; k > 0; k = k / 10)
      exp_q.push_back(8'(CH_ZERO + (mag / k) % 10));
    if (dflt) begin
      exp_q = {exp_q, CH_T, CH_PLUS, CH_TEMP1, CH_TEMP0, CH_D};
      s = 8'h00;
      foreach (exp_q[i]) s = s + exp_q[i];
      exp_q = {exp_q, hexc(s[7:4]), hexc(s[3:0])};
    end
    exp_q.push_back(CH_CR);
  endtask

  // ==========================================
  // scenarios
  task automatic t_quiet();
    int lows;
    @(negedge MCLK);
    SRC_EN_N = 1'b0;
    ovr_en = 1'b1;
    ovr = 11'h7F8;
    wait_idle();
    lows = 0;
    repeat (2 * UPD) begin
      @(negedge MCLK);
      lows += (TXD1 !== 1'b1);
    end
    check(lows, 0);
    check(PAR1_OE | PAR2_OE, '0);
    $display("test quiet done");
  endtask

  task automatic t_msg(input int ft, input bit dflt, input bit off,
                       input bit oen, input logic [CODE_W-1:0] oc,
                       input bit wig);
    int n;
    @(negedge MCLK);
    PROTO_SEL = dflt;
    SRC_EN_N = off;
    feet = ft;
    ovr_en = oen;
    ovr = oc;
    wiggle = wig;
    rx_div = dflt ? 16'(SLOW) : 16'(FAST);
    wait_idle();
    build((!dflt && (off || oen)) ? 99900 : ft, dflt);
    n = 0;
    while (agts_partner_inst.rx_q.size() < exp_q.size()
           && n < 2 * UPD + 400) begin
      @(posedge MCLK);
      n++;
    end
    wiggle = 1'b0;
    check(agts_partner_inst.rx_q.size(), exp_q.size());
    foreach (exp_q[i]) begin
      check(agts_partner_inst.rx_q[i], exp_q[i]);
    end
    check(agts_partner_inst.frame_err, 0);
    $display("test message %0d done", ft);
  endtask

  task automatic t_par(input logic [CODE_W-1:0] c);
    @(negedge MCLK);
    SRC_EN_N = 1'b0;
    ovr_en = 1'b1;
    ovr = c;
    STROBE_N = 1'b0;
    repeat (2) @(negedge MCLK);
    check(PAR1_OE, c);
    check(PAR2_OE, c);
    check(pin1, CODE_W'(~c));
    check(PAR1_O | PAR2_O, '0);
    STROBE_N = 1'b1;
    #1;
    check(PAR1_OE | PAR2_OE, '0);
    $display("test parallel %h done", c);
  endtask

  initial begin
    RSTN = 1'b0;
    SRC_EN_N = 1'b1;
    PROTO_SEL = 1'b1;
    STROBE_N = 1'b0;
    feet = 0;
    ovr_en = 1'b0;
    ovr = '0;
    wiggle = 1'b0;
    rx_div = 16'(SLOW);
    fail_count = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (8) @(negedge MCLK);
    check(TXD1, 1'b1);
    check(PAR1_OE | PAR2_OE, '0);
    RSTN = 1'b1;
    t_quiet();
    t_msg(800, 1, 0, 0, '0, 0);
    t_msg(-1000, 1, 0, 0, '0, 1);
    t_msg(10500, 0, 0, 0, '0, 1);
    t_msg(-1000, 0, 0, 0, '0, 0);
    t_msg(0, 0, 1, 0, '0, 0);
    t_msg(0, 0, 0, 1, 11'h7F8, 0);
    t_msg(62700, 1, 0, 0, '0, 0);
    foreach (codes[i]) t_par(codes[i]);
    print_verdict();
  end
endmodule
`default_nettype wire

// ===== verilog/agts_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module agts_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,       // clock
  input  wire logic         rst_n,     // async reset, low
  input  wire logic         in_valid,  // write request
  output logic              in_ready,  // space left
  input  wire logic [W-1:0] in_data,   // write word
  output logic              out_valid, // word available
  input  wire logic         out_ready, // read accept
  output logic [W-1:0]      out_data   // head word
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
    $error("agts_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  logic         push;
  logic         pop;

  assign in_ready  = (wr_q - rd_q) != (AW + 1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  chk_full_blocks: assert property (@(posedge clk)
    disable iff (!rst_n) (wr_q - rd_q) <= (AW + 1)'(DEPTH))
    else $error("fifo holds more words than its depth");

endmodule
`default_nettype wire

// ===== verilog/agts_pkg.sv
package agts_pkg;

  // =====================================================
  // clock and serial timing
  localparam int CLK_HZ          = 100_000_000;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int BPS_DEFAULT     = 1200;
  localparam int BPS_ALT         = 9600;
  localparam int UPDATE_PER_S    = 1;
  localparam int BAUD_DIV_DEFAULT = CLK_HZ / BPS_DEFAULT;
  localparam int BAUD_DIV_ALT     = CLK_HZ / BPS_ALT;
  localparam int UPDATE_DIV       = CLK_HZ / UPDATE_PER_S;
  localparam int CNT_W            = 32;

  // =====================================================
  // altitude code bit positions
  localparam int CODE_W  = 11;
  localparam int POS_D2  = 10;
  localparam int POS_B4  = 3;
  localparam int POS_C1  = 2;
  localparam int POS_C2  = 1;
  localparam int POS_C4  = 0;
  localparam int GRAY_W  = 8;
  localparam int ALT_OFFSET_100FT = 12;
  localparam int ALT_MAX_100FT    = 999;
  localparam logic [3:0] DISABLED_DIGIT = 4'h9;

  // =====================================================
  // messages
  localparam int LEN_DEFAULT = 17;
  localparam int LEN_ALT     = 10;
  localparam int IDX_W       = 5;
  localparam int SUM_LAST    = 13;
  localparam int FIFO_DEPTH  = 8;
  localparam int FIFO_W      = 9;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_HASH  = 8'h23;
  localparam logic [7:0] CH_PLUS  = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CH_L     = 8'h4C;
  localparam logic [7:0] CH_T     = 8'h54;
  localparam logic [7:0] CH_D     = 8'h44;
  localparam logic [7:0] CH_TEMP1 = 8'h32;
  localparam logic [7:0] CH_TEMP0 = 8'h35;

  typedef enum logic [1:0] {
    GEN_IDLE = 2'b00,
    GEN_SEND = 2'b01
  } agts_gen_type;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b10,
    TX_STOP  = 2'b11
  } agts_tx_type;

endpackage

// ===== verilog/agts_top.sv
`timescale 1ns/1ps
`default_nettype none
module agts_top
  import agts_pkg::*;
#(
  parameter int BAUD_DIV_SLOW = agts_pkg::BAUD_DIV_DEFAULT,
  parameter int BAUD_DIV_FAST = agts_pkg::BAUD_DIV_ALT,
  parameter int UPDATE_CYCLES = agts_pkg::UPDATE_DIV
) (
  input  wire logic                      MCLK,       // 100 MHz clock
  input  wire logic                      RSTN,       // async reset, low
  input  wire logic [agts_pkg::CODE_W-1:0] ALT_CODE, // input code, 1 = set
  input  wire logic                      SRC_EN_N,   // source common, low = on
  input  wire logic                      PROTO_SEL,  // strap, 1 open, 0 ground
  input  wire logic                      STROBE_N,   // parallel enable, low = on
  output logic [agts_pkg::CODE_W-1:0]    PAR1_O,     // port 1 pin level driven
  output logic [agts_pkg::CODE_W-1:0]    PAR1_OE,    // port 1 sink enable
  output logic [agts_pkg::CODE_W-1:0]    PAR2_O,     // port 2 pin level driven
  output logic [agts_pkg::CODE_W-1:0]    PAR2_OE,    // port 2 sink enable
  output logic                           TXD1,       // serial out 1
  output logic                           TXD2        // serial out 2
);
  import agts_pkg::*;

  if (BAUD_DIV_SLOW < 2 || BAUD_DIV_FAST < 2 ||
      UPDATE_CYCLES < 2) begin : g_bad
    $error("agts_top: dividers must be at least 2");
  end

  // =====================================================
  // decode helpers
  function automatic logic [2:0] c_step(input logic [2:0] c);
    case (c)
      3'h1:    c_step = 3'h1;
      3'h3:    c_step = 3'h2;
      3'h2:    c_step = 3'h3;
      3'h6:    c_step = 3'h4;
      3'h4:    c_step = 3'h5;
      default: c_step = 3'h0;
    endcase
  endfunction

  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    hex_ch = (n < 4'hA) ? CH_ZERO + {4'h0, n} : 8'h37 + {4'h0, n};
  endfunction

  // =====================================================
  // input capture and decode
  logic [CODE_W-1:0] code_q;
  logic              src_on_q;
  logic              valid_seen_q;
  logic [2:0]        cfield;
  logic [2:0]        cstep;
  logic [GRAY_W-1:0] gray;
  logic [GRAY_W-1:0] n500;
  logic              code_ok;
  int                h100;
  int                mag;
  logic              neg;
  logic [3:0]        dig2;
  logic [3:0]        dig1;
  logic [3:0]        dig0;

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      code_q   <= '0;
      src_on_q <= 1'b0;
    end else begin
      code_q   <= ALT_CODE;
      src_on_q <= !SRC_EN_N;
    end
  end

  assign cfield  = {code_q[POS_C1], code_q[POS_C2], code_q[POS_C4]};
  assign cstep   = c_step(cfield);
  assign gray    = code_q[POS_D2:POS_B4];
  assign code_ok = src_on_q && (cstep != 3'h0);

  always_comb begin
    n500[GRAY_W-1] = gray[GRAY_W-1];
    for (int i = GRAY_W - 2; i >= 0; i--) begin
      n500[i] = n500[i+1] ^ gray[i];
    end
  end

  always_comb begin
    int c;
    c = int'(cstep);
    if (n500[0]) begin
      c = 6 - c;
    end
    h100 = int'(n500) * 5 + c - 1 - ALT_OFFSET_100FT;
    neg  = h100 < 0;
    mag  = neg ? -h100 : h100;
    if (mag > ALT_MAX_100FT) begin
      mag = ALT_MAX_100FT;
    end
    dig2 = 4'(mag / 100);
    dig1 = 4'((mag / 10) % 10);
    dig0 = 4'(mag % 10);
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      valid_seen_q <= 1'b0;
    end else if (code_ok) begin
      valid_seen_q <= 1'b1;
    end
  end

  // =====================================================
  // parallel repeat, open collector
  logic [CODE_W-1:0] par_oe;

  assign par_oe  = (valid_seen_q && !STROBE_N) ? code_q : '0;
  assign PAR1_O  = '0;
  assign PAR2_O  = '0;
  assign PAR1_OE = par_oe;
  assign PAR2_OE = par_oe;

  chk_par_strobe: assert property (@(posedge MCLK)
    disable iff (!RSTN) STROBE_N |-> (PAR1_OE == '0 && PAR2_OE == '0))
    else $error("parallel driven while strobe off");

  chk_par_follow: assert property (@(posedge MCLK)
    disable iff (!RSTN) (valid_seen_q && !STROBE_N && $past(RSTN))
      |-> (PAR1_OE == $past(ALT_CODE)))
    else $error("parallel output does not follow input");

  // =====================================================
  // message generator
  agts_gen_type      gen_q;
  logic [CNT_W-1:0]  upd_q;
  logic              tick;
  logic              mode_q;
  logic              neg_q;
  logic [3:0]        d2_q;
  logic [3:0]        d1_q;
  logic [3:0]        d0_q;
  logic [IDX_W-1:0]  idx_q;
  logic [7:0]        sum_q;
  logic [IDX_W-1:0]  last_idx;
  logic [7:0]        byte_d;
  logic              f_in_ready;
  logic              push;
  logic              start_ok;

  assign tick     = upd_q == CNT_W'(UPDATE_CYCLES - 1);
  assign last_idx = mode_q ? IDX_W'(LEN_DEFAULT - 1) : IDX_W'(LEN_ALT - 1);
  assign push     = (gen_q == GEN_SEND);
  assign start_ok = valid_seen_q && (!PROTO_SEL || code_ok);

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      upd_q <= '0;
    end else if (tick) begin
      upd_q <= '0;
    end else begin
      upd_q <= upd_q + 1'b1;
    end
  end

  always_comb begin
    byte_d = CH_CR;
    if (mode_q) begin
      case (idx_q)
        5'h00:   byte_d = CH_HASH;
        5'h01:   byte_d = CH_A;
        5'h02:   byte_d = CH_L;
        5'h03:   byte_d = neg_q ? CH_MINUS : CH_PLUS;
        5'h04:   byte_d = CH_ZERO + {4'h0, d2_q};
        5'h05:   byte_d = CH_ZERO + {4'h0, d1_q};
        5'h06:   byte_d = CH_ZERO + {4'h0, d0_q};
        5'h07:   byte_d = CH_ZERO;
        5'h08:   byte_d = CH_ZERO;
        5'h09:   byte_d = CH_T;
        5'h0A:   byte_d = CH_PLUS;
        5'h0B:   byte_d = CH_TEMP1;
        5'h0C:   byte_d = CH_TEMP0;
        5'h0D:   byte_d = CH_D;
        5'h0E:   byte_d = hex_ch(sum_q[7:4]);
        5'h0F:   byte_d = hex_ch(sum_q[3:0]);
        default: byte_d = CH_CR;
      endcase
    end else begin
      case (idx_q)
        5'h00:   byte_d = CH_A;
        5'h01:   byte_d = CH_L;
        5'h02:   byte_d = CH_T;
        5'h03:   byte_d = CH_SP;
        5'h04:   byte_d = CH_ZERO + {4'h0, d2_q};
        5'h05:   byte_d = CH_ZERO + {4'h0, d1_q};
        5'h06:   byte_d = CH_ZERO + {4'h0, d0_q};
        5'h07:   byte_d = CH_ZERO;
        5'h08:   byte_d = CH_ZERO;
        default: byte_d = CH_CR;
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      gen_q  <= GEN_IDLE;
      mode_q <= 1'b1;
      neg_q  <= 1'b0;
      d2_q   <= '0;
      d1_q   <= '0;
      d0_q   <= '0;
      idx_q  <= '0;
      sum_q  <= '0;
    end else begin
      case (gen_q)
        GEN_IDLE: begin
          if (tick && start_ok) begin
            gen_q  <= GEN_SEND;
            mode_q <= PROTO_SEL;
            idx_q  <= '0;
            sum_q  <= '0;
            if (!code_ok) begin
              neg_q <= 1'b0;
              d2_q  <= DISABLED_DIGIT;
              d1_q  <= DISABLED_DIGIT;
              d0_q  <= DISABLED_DIGIT;
            end else begin
              neg_q <= neg;
              d2_q  <= dig2;
              d1_q  <= dig1;
              d0_q  <= dig0;
            end
          end
        end
        GEN_SEND: begin
          if (f_in_ready) begin
            if (idx_q <= IDX_W'(SUM_LAST)) begin
              sum_q <= sum_q + byte_d;
            end
            if (idx_q == last_idx) begin
              gen_q <= GEN_IDLE;
            end else begin
              idx_q <= idx_q + 1'b1;
            end
          end
        end
        default: gen_q <= GEN_IDLE;
      endcase
    end
  end

  chk_no_early_send: assert property (@(posedge MCLK)
    disable iff (!RSTN)
    !valid_seen_q |-> (gen_q == GEN_IDLE && TXD1 && TXD2))
    else $error("output before valid altitude");

  chk_disabled_value: assert property (@(posedge MCLK)
    disable iff (!RSTN)
    (gen_q == GEN_IDLE && tick && start_ok && !code_ok) |=>
      (!mode_q && d2_q == 4'h9 && d1_q == 4'h9 && d0_q == 4'h9))
    else $error("disabled source not reported as 99900");

  chk_msg_length: assert property (@(posedge MCLK)
    disable iff (!RSTN)
    (push && f_in_ready && byte_d == CH_CR) |->
      (idx_q == (mode_q ? 5'h10 : 5'h09)))
    else $error("message ends at wrong length");

  // =====================================================
  // character buffer
  logic              f_out_valid;
  logic              f_out_ready;
  logic [FIFO_W-1:0] f_out_data;

  agts_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (MCLK),
    .rst_n     (RSTN),
    .in_valid  (push),
    .in_ready  (f_in_ready),
    .in_data   ({mode_q, byte_d}),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // =====================================================
  // serial transmitter
  agts_tx_type       tx_q;
  logic [CNT_W-1:0]  baud_q;
  logic [CNT_W-1:0]  div_q;
  logic [7:0]        sh_q;
  logic [2:0]        bit_q;
  logic              txd_q;
  logic              bit_end;

  assign bit_end     = baud_q == div_q - 1'b1;
  assign f_out_ready = (tx_q == TX_IDLE);

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_q   <= TX_IDLE;
      baud_q <= '0;
      div_q  <= CNT_W'(BAUD_DIV_SLOW);
      sh_q   <= '0;
      bit_q  <= '0;
      txd_q  <= 1'b1;
    end else begin
      baud_q <= bit_end ? '0 : baud_q + 1'b1;
      case (tx_q)
        TX_IDLE: begin
          txd_q  <= 1'b1;
          baud_q <= '0;
          if (f_out_valid) begin
            div_q <= f_out_data[8] ? CNT_W'(BAUD_DIV_SLOW)
                                   : CNT_W'(BAUD_DIV_FAST);
            sh_q  <= f_out_data[7:0];
            txd_q <= 1'b0;
            tx_q  <= TX_START;
          end
        end
        TX_START: begin
          if (bit_end) begin
            txd_q <= sh_q[0];
            sh_q  <= {1'b0, sh_q[7:1]};
            bit_q <= '0;
            tx_q  <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (bit_end) begin
            if (bit_q == 3'h7) begin
              txd_q <= 1'b1;
              tx_q  <= TX_STOP;
            end else begin
              txd_q <= sh_q[0];
              sh_q  <= {1'b0, sh_q[7:1]};
              bit_q <= bit_q + 1'b1;
            end
          end
        end
        TX_STOP: begin
          if (bit_end) begin
            tx_q <= TX_IDLE;
          end
        end
        default: tx_q <= TX_IDLE;
      endcase
    end
  end

  assign TXD1 = txd_q;
  assign TXD2 = txd_q;

  chk_start_low: assert property (@(posedge MCLK) disable iff (!RSTN)
    (tx_q == TX_IDLE && f_out_valid) |=> (!TXD1 && tx_q == TX_START))
    else $error("start bit missing");

  chk_stop_mark: assert property (@(posedge MCLK) disable iff (!RSTN)
    (tx_q == TX_STOP || tx_q == TX_IDLE) |-> TXD1)
    else $error("stop or idle not at mark");

  chk_rate_mode: assert property (@(posedge MCLK) disable iff (!RSTN)
    (tx_q == TX_IDLE && f_out_valid) |=>
      (div_q == ($past(f_out_data[8]) ? BAUD_DIV_SLOW : BAUD_DIV_FAST)))
    else $error("bit time does not match protocol");

  chk_ports_equal: assert property (@(posedge MCLK)
    disable iff (!RSTN) (TXD1 == TXD2) && ($fell(TXD1) == $fell(TXD2)))
    else $error("serial ports differ");

endmodule
`default_nettype wire
